// [rtl/pcq_task_ctrl.sv]
`timescale 1ns/10ps
`include "pcq_regs.svh"
// Behaviour
// - sink-caps task sends Get_Sink_Cap as soon as the policy engine allows
// - both tasks leave the return code in task data buffer byte zero
// - sink-caps task ends on a sink caps reply or on a failure
// - sink-caps task rejected when partner is a known source without dual role
// - sink-caps task rejected on Reject or Not_Supported reply
// - either task times out when no reply within the response time
// - sink-caps success needs request GoodCRC'ed and sink caps processed
// - successful sink-caps task refreshes received sink caps at 0x31
// - source-caps task sends Get_Source_Cap as soon as policy allows
// - source-caps task ends on a source caps reply or on a failure
// - source-caps task rejected when partner is a known sink without dual role
// - source-caps task rejected on Reject or Not_Supported reply
// - source-caps success needs request GoodCRC'ed and caps processed
// - successful source-caps task refreshes received source caps at 0x30
module pcq_task_ctrl
  import pcq_pkg::*;
(
  input  wire logic        ref_clk,    // 40 MHz clock
  input  wire logic        srst,       // sync reset, active high
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  input  wire logic        wb_we_i,    // wishbone write
  input  wire logic [7:0]  wb_adr_i,   // wishbone word index
  input  wire logic [3:0]  wb_sel_i,   // wishbone byte select
  input  wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic [31:0]      wb_dat_o,   // wishbone read data
  output logic             wb_ack_o,   // wishbone ack
  output logic             irq_o,      // level interrupt
  input  wire logic        pe_ready,   // policy engine may send now
  output logic             tx_req,     // request send, held until taken
  output logic [2:0]       tx_kind,    // 1 get sink caps, 2 get src caps
  input  wire logic        tx_goodcrc, // request acknowledged by GoodCRC
  input  wire logic        tx_fail,    // request not GoodCRC'ed
  input  wire logic        rx_valid,   // received message strobe
  input  wire logic [2:0]  rx_kind,    // received message kind
  input  wire logic [7:0]  rx_caps     // processed capability summary
);

  localparam logic [15:0] RESP_CYC = 16'(`PCQ_RESP_CYCLES);

  pcq_state_s_t cur_ff;
  pcq_state_s_t nxt_ff;

  logic       bus_req;
  logic       bus_wr;
  logic       rx_ok;
  logic       rx_neg;
  logic [2:0] ev;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  // reply classification for the task that is running
  assign rx_ok  = rx_valid & (cur_ff.is_snk ?
                   (rx_kind == PCQ_MSG_SNK_CAP) :
                   (rx_kind == PCQ_MSG_SRC_CAP));
  assign rx_neg = rx_valid & ((rx_kind == PCQ_MSG_REJECT) |
                   (rx_kind == PCQ_MSG_NOT_SUP));

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_ff        = cur_ff;
    ev            = 3'h0;
    nxt_ff.ack    = 1'b0;
    nxt_ff.dat_o  = 32'h0;

    case (cur_ff.state)
      PCQ_IDLE:
      begin
        nxt_ff.tx_req = 1'b0;
      end
      PCQ_SEND:
      begin
        // partner role already rules the query out
        if (cur_ff.is_snk && cur_ff.partner[`PCQ_PRT_CAP_KNOWN] &&
            cur_ff.partner[`PCQ_PRT_IS_SRC] &&
            cur_ff.partner[`PCQ_PRT_NO_DRP])
        begin
          nxt_ff.ret_code = `PCQ_RC_REJECTED;
          nxt_ff.state    = PCQ_FINISH;
        end
        else if (!cur_ff.is_snk && cur_ff.partner[`PCQ_PRT_CAP_KNOWN] &&
                 !cur_ff.partner[`PCQ_PRT_IS_SRC] &&
                 cur_ff.partner[`PCQ_PRT_NO_DRP])
        begin
          nxt_ff.ret_code = `PCQ_RC_REJECTED;
          nxt_ff.state    = PCQ_FINISH;
        end
        else if (pe_ready)
        begin
          // first opportunity the policy engine grants
          nxt_ff.tx_req  = 1'b1;
          nxt_ff.tx_kind = cur_ff.is_snk ? PCQ_MSG_SNK_CAP
                                         : PCQ_MSG_SRC_CAP;
          nxt_ff.timer   = RESP_CYC;
          nxt_ff.state   = PCQ_WAIT;
        end
      end
      PCQ_WAIT:
      begin
        if (tx_goodcrc)
        begin
          nxt_ff.tx_req = 1'b0;
        end
        if (cur_ff.timer != 16'h0)
        begin
          nxt_ff.timer = cur_ff.timer - 16'h1;
        end
        if (rx_ok && !cur_ff.tx_req)
        begin
          // success only after GoodCRC dropped tx_req
          nxt_ff.ret_code = `PCQ_RC_SUCCESS;
          if (cur_ff.is_snk)
          begin
            nxt_ff.rx_snk = rx_caps;
          end
          else
          begin
            nxt_ff.rx_src = rx_caps;
          end
          nxt_ff.state = PCQ_FINISH;
        end
        else if (rx_neg && !cur_ff.tx_req)
        begin
          nxt_ff.ret_code = `PCQ_RC_REJECTED;
          nxt_ff.state    = PCQ_FINISH;
        end
        else if (tx_fail || cur_ff.timer == 16'h0)
        begin
          nxt_ff.tx_req   = 1'b0;
          nxt_ff.ret_code = `PCQ_RC_TIMEOUT;
          nxt_ff.state    = PCQ_FINISH;
        end
      end
      PCQ_FINISH:
      begin
        // return code is already in the buffer low byte
        nxt_ff.busy  = 1'b0;
        nxt_ff.done  = 1'b1;
        ev[`PCQ_IRQ_DONE] = 1'b1;
        ev[`PCQ_IRQ_REJ]  = (cur_ff.ret_code == `PCQ_RC_REJECTED);
        ev[`PCQ_IRQ_TMO]  = (cur_ff.ret_code == `PCQ_RC_TIMEOUT);
        nxt_ff.state = PCQ_IDLE;
      end
      default:
      begin
        nxt_ff.state = PCQ_IDLE;
      end
    endcase

    // register writes; a new task is ignored while one runs (host waits)
    if (bus_wr)
    begin
      case (wb_adr_i)
        `PCQ_IDX_TASK_CMD:
        begin
          if (!cur_ff.busy)
          begin
            nxt_ff.cmd  = wb_dat_i[7:0];
            nxt_ff.done = 1'b0;
            if (wb_dat_i[7:0] == `PCQ_CMD_GET_SNK ||
                wb_dat_i[7:0] == `PCQ_CMD_GET_SRC)
            begin
              nxt_ff.busy   = 1'b1;
              nxt_ff.is_snk = (wb_dat_i[7:0] == `PCQ_CMD_GET_SNK);
              nxt_ff.state  = PCQ_SEND;
            end
            else
            begin
              nxt_ff.ret_code = `PCQ_RC_BAD_CMD;
              nxt_ff.done     = 1'b1;
            end
          end
        end
        `PCQ_IDX_IRQ_STAT:
        begin
          nxt_ff.irq_stat = cur_ff.irq_stat & ~wb_dat_i[2:0];
        end
        `PCQ_IDX_IRQ_MASK:
        begin
          nxt_ff.irq_mask = wb_dat_i[2:0];
        end
        `PCQ_IDX_PARTNER:
        begin
          nxt_ff.partner = wb_dat_i[2:0];
        end
        default:
        begin
        end
      endcase
    end

    // set wins over a same-cycle write-one clear
    nxt_ff.irq_stat = nxt_ff.irq_stat | ev;
    nxt_ff.irq      = |(nxt_ff.irq_stat & nxt_ff.irq_mask);

    // read path; unmapped indices answer zero with ack
    if (bus_req)
    begin
      nxt_ff.ack = 1'b1;
      if (!wb_we_i)
      begin
        case (wb_adr_i)
          `PCQ_IDX_TASK_CMD:  nxt_ff.dat_o = {24'h0, cur_ff.cmd};
          `PCQ_IDX_TASK_DATA: nxt_ff.dat_o = {24'h0, cur_ff.ret_code};
          `PCQ_IDX_STATUS:
            nxt_ff.dat_o = {30'h0, cur_ff.done, cur_ff.busy};
          `PCQ_IDX_IRQ_STAT:  nxt_ff.dat_o = {29'h0, cur_ff.irq_stat};
          `PCQ_IDX_IRQ_MASK:  nxt_ff.dat_o = {29'h0, cur_ff.irq_mask};
          `PCQ_IDX_PARTNER:   nxt_ff.dat_o = {29'h0, cur_ff.partner};
          `PCQ_IDX_RX_SRC:    nxt_ff.dat_o = {24'h0, cur_ff.rx_src};
          `PCQ_IDX_RX_SNK:    nxt_ff.dat_o = {24'h0, cur_ff.rx_snk};
          default:            nxt_ff.dat_o = 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cur_ff          <= '0;
      cur_ff.state    <= PCQ_IDLE;
      cur_ff.rx_src   <= `PCQ_RX_CAPS_RST;
      cur_ff.rx_snk   <= `PCQ_RX_CAPS_RST;
      cur_ff.irq_mask <= `PCQ_IRQ_MASK_RST;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = cur_ff.dat_o;
  assign wb_ack_o = cur_ff.ack;
  assign irq_o    = cur_ff.irq;
  assign tx_req   = cur_ff.tx_req;
  assign tx_kind  = cur_ff.tx_kind;

endmodule

// [shared/pcq_regs.svh]
`ifndef PCQ_REGS_SVH
`define PCQ_REGS_SVH
// ----------------------------------------------------------------------
// register offsets (word index; byte address is four times the index)
// ----------------------------------------------------------------------
`define PCQ_IDX_RX_SRC      8'h30
`define PCQ_IDX_RX_SNK      8'h31
`define PCQ_IDX_TASK_CMD    8'h00
`define PCQ_IDX_TASK_DATA   8'h01
`define PCQ_IDX_STATUS      8'h02
`define PCQ_IDX_IRQ_STAT    8'h03
`define PCQ_IDX_IRQ_MASK    8'h04
`define PCQ_IDX_PARTNER     8'h05
// ----------------------------------------------------------------------
// task command codes and return codes
// ----------------------------------------------------------------------
`define PCQ_CMD_GET_SNK     8'h01
`define PCQ_CMD_GET_SRC     8'h02
`define PCQ_RC_SUCCESS      8'h00
`define PCQ_RC_TIMEOUT      8'h01
`define PCQ_RC_REJECTED     8'h02
`define PCQ_RC_BAD_CMD      8'h03
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCQ_ST_BUSY         0
`define PCQ_ST_DONE         1
`define PCQ_IRQ_DONE        0
`define PCQ_IRQ_REJ         1
`define PCQ_IRQ_TMO         2
`define PCQ_PRT_IS_SRC      0
`define PCQ_PRT_NO_DRP      1
`define PCQ_PRT_CAP_KNOWN   2
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define PCQ_RX_CAPS_RST     8'h00
`define PCQ_IRQ_MASK_RST    3'h0
`define PCQ_RESP_TIME_US    30
`define PCQ_CLK_MHZ         40
`define PCQ_RESP_CYCLES     (`PCQ_RESP_TIME_US * `PCQ_CLK_MHZ)
`endif

// [shared/pcq_pkg.sv]
package pcq_pkg;
  // message kinds exchanged with the protocol layer
  typedef enum logic [2:0] {
    PCQ_MSG_NONE    = 3'h0,
    PCQ_MSG_SNK_CAP = 3'h1,
    PCQ_MSG_SRC_CAP = 3'h2,
    PCQ_MSG_REJECT  = 3'h3,
    PCQ_MSG_NOT_SUP = 3'h4
  } pcq_msg_t;

  // task sequencer, gray along idle-send-wait-finish
  typedef enum logic [1:0] {
    PCQ_IDLE   = 2'b00,
    PCQ_SEND   = 2'b01,
    PCQ_WAIT   = 2'b11,
    PCQ_FINISH = 2'b10
  } pcq_state_t;

  typedef struct packed {
    pcq_state_t  state;
    logic        is_snk;
    logic [15:0] timer;
    logic [7:0]  cmd;
    logic [7:0]  ret_code;
    logic [7:0]  rx_src;
    logic [7:0]  rx_snk;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  partner;
    logic        busy;
    logic        done;
    logic        tx_req;
    logic [2:0]  tx_kind;
    logic        ack;
    logic [31:0] dat_o;
    logic        irq;
  } pcq_state_s_t;
endpackage

// [testbench/pcq_task_ctrl_properties.sv]
`timescale 1ns/10ps
module pcq_task_ctrl_properties (
  input wire logic        ref_clk,    // clock
  input wire logic        srst,       // sync reset
  input wire logic        wb_cyc_i,   // cycle
  input wire logic        wb_stb_i,   // strobe
  input wire logic [31:0] wb_dat_o,   // read data
  input wire logic        wb_ack_o,   // ack
  input wire logic        pe_ready,   // send allowed
  input wire logic        tx_req,     // send request
  input wire logic [2:0]  tx_kind,    // request kind
  input wire logic        tx_goodcrc, // send taken
  input wire logic        tx_fail     // send lost
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------------
  // bus handshake and send request
  // ------------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_pulse)
    else $error("ack not one pulse after request");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_req_ready: assert property ($rose(tx_req) |-> $past(pe_ready))
    else $error("send raised while engine not ready");
  a_req_held: assert property (tx_req && !tx_goodcrc && !tx_fail |=> tx_req)
    else $error("send dropped before taken");
  a_req_drop: assert property (tx_req && (tx_goodcrc || tx_fail) |=> !tx_req)
    else $error("send held after taken");
  a_kind_legal: assert property (tx_req |-> tx_kind inside {3'h1, 3'h2})
    else $error("send kind not a capability query");
  a_req_gap: assert property ($fell(tx_req) |-> !tx_req [*3])
    else $error("second send within one task");
endmodule

bind pcq_task_ctrl pcq_task_ctrl_properties u_pcq_task_ctrl_properties (
  .ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pe_ready,
  .tx_req, .tx_kind, .tx_goodcrc, .tx_fail);

// [testbench/pcq_partner.sv]
`timescale 1ns/10ps
module pcq_partner
  import pcq_pkg::*;
(
  input  wire logic       ref_clk,           // clock
  input  wire logic       srst,              // sync reset
  input  wire logic       stall,             // hold the engine off
  input  wire logic [2:0] reply,             // reply kind, none is silent
  input  wire logic       nack,              // let the send fail
  input  wire logic [7:0] caps,              // payload to return
  input  wire logic       tx_req,            // send request
  output logic            pe_ready   = 1'b0, // send allowed
  output logic            tx_goodcrc = 1'b0, // send taken
  output logic            tx_fail    = 1'b0, // send lost
  output logic            rx_valid   = 1'b0, // reply strobe
  output logic [2:0]      rx_kind    = 3'h0, // reply kind
  output logic [7:0]      rx_caps    = 8'h0  // reply payload
);
  logic [2:0] cnt_ff = 3'h0; // wraps to idle after the reply
  // ack after three cycles, reply only once the request has dropped;
  // lines carry inverted data outside the strobe so stale use shows
  always @(posedge ref_clk)
  begin
    if (srst)
      cnt_ff <= 3'h0;
    else if (cnt_ff != 3'h0 || tx_req)
      cnt_ff <= cnt_ff + 3'h1;
    pe_ready   <= !stall && !srst;
    tx_goodcrc <= cnt_ff == 3'h3 && !nack;
    tx_fail    <= cnt_ff == 3'h3 && nack;
    rx_valid   <= cnt_ff == 3'h6 && !nack && reply != PCQ_MSG_NONE;
    rx_kind    <= (cnt_ff == 3'h6) ? reply : ~reply;
    rx_caps    <= (cnt_ff == 3'h6) ? caps : ~caps;
  end
endmodule

// [testbench/tb_pcq_task_ctrl.sv]
`timescale 1ns/10ps
`include "pcq_regs.svh"
module tb_pcq_task_ctrl
  import pcq_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] prt;
    logic [2:0] rep;
    logic       nk;
    logic [7:0] cp;
    logic [7:0] rc;
    logic [2:0] msk;
  } pcq_case_t;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, irq_o, pe_ready, tx_req, tx_goodcrc, tx_fail;
  logic        rx_valid, stall = 1'b0, nack = 1'b0;
  logic [2:0]  tx_kind, rx_kind, reply = 3'h0;
  logic [7:0]  rx_caps, caps = 8'h0;
  logic [7:0]  exp_snk = `PCQ_RX_CAPS_RST, exp_src = `PCQ_RX_CAPS_RST;
  logic [2:0]  seen_kind = 3'h0;
  int          fail_count = 0, n_compared = 0, cycles = 0;
  pcq_case_t   tbl [10] = '{
    '{`PCQ_CMD_GET_SNK, 3'h0, PCQ_MSG_SNK_CAP, 1'b0, 8'hA5, 8'h00, 3'h7},
    '{`PCQ_CMD_GET_SRC, 3'h0, PCQ_MSG_SRC_CAP, 1'b0, 8'h3C, 8'h00, 3'h2},
    '{`PCQ_CMD_GET_SNK, 3'h0, PCQ_MSG_REJECT, 1'b0, 8'h11, 8'h02, 3'h7},
    '{`PCQ_CMD_GET_SRC, 3'h0, PCQ_MSG_NOT_SUP, 1'b0, 8'h22, 8'h02, 3'h7},
    '{`PCQ_CMD_GET_SNK, 3'h7, PCQ_MSG_SNK_CAP, 1'b0, 8'h33, 8'h02, 3'h7},
    '{`PCQ_CMD_GET_SRC, 3'h6, PCQ_MSG_SRC_CAP, 1'b0, 8'h44, 8'h02, 3'h7},
    '{`PCQ_CMD_GET_SNK, 3'h1, PCQ_MSG_SNK_CAP, 1'b0, 8'h5A, 8'h00, 3'h7},
    '{`PCQ_CMD_GET_SRC, 3'h0, PCQ_MSG_NONE, 1'b0, 8'h66, 8'h01, 3'h7},
    '{`PCQ_CMD_GET_SNK, 3'h0, PCQ_MSG_SRC_CAP, 1'b0, 8'h77, 8'h01, 3'h4},
    '{`PCQ_CMD_GET_SRC, 3'h0, PCQ_MSG_SRC_CAP, 1'b1, 8'h88, 8'h01, 3'h7}};
  // rows: success, masked done, replies refused, partner role refusals,
  // dual-role source accepted, silence, wrong reply kind, lost send

  pcq_task_ctrl u_pcq_task_ctrl (.ref_clk, .srst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
    .pe_ready, .tx_req, .tx_kind, .tx_goodcrc, .tx_fail, .rx_valid, .rx_kind,
    .rx_caps);
  pcq_partner u_pcq_partner (.ref_clk, .srst, .stall, .reply, .nack, .caps,
    .tx_req, .pe_ready, .tx_goodcrc, .tx_fail, .rx_valid, .rx_kind, .rx_caps);

  // clock, and a ceiling well above two response timeouts plus polling
  always #12.5 ref_clk = ~ref_clk;
  // last request kind the design put on the link
  always @(posedge ref_clk)
  begin
    if (tx_req === 1'b1)
      seen_kind <= tx_kind;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is sampled high, then released
  task automatic wb_xfer(input logic [7:0] a, input logic w,
                         input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // run one task with the engine held off first, then check every result
  task automatic run_case(input pcq_case_t c);
    logic [2:0] st;
    wb_xfer(`PCQ_IDX_IRQ_MASK, 1'b1, {29'h0, c.msk}, q);
    wb_xfer(`PCQ_IDX_PARTNER, 1'b1, {29'h0, c.prt}, q);
    reply <= c.rep;
    nack  <= c.nk;
    caps  <= c.cp;
    stall <= 1'b1;
    wb_xfer(`PCQ_IDX_TASK_CMD, 1'b1, {24'h0, c.cmd}, q);
    repeat (8) @(posedge ref_clk);
    check("send while held off", {31'h0, tx_req}, 32'h0);
    stall <= 1'b0;
    q = 32'h1;
    while (q[`PCQ_ST_BUSY] !== 1'b0)
      wb_xfer(`PCQ_IDX_STATUS, 1'b0, 32'h0, q);
    check("done", {31'h0, q[`PCQ_ST_DONE]}, 32'h1);
    if (c.prt[2:1] != 2'b11)
      check("send kind", {29'h0, seen_kind},
            (c.cmd == `PCQ_CMD_GET_SNK) ? 32'h1 : 32'h2);
    wb_xfer(`PCQ_IDX_TASK_DATA, 1'b0, 32'h0, q);
    check("return code", q & 32'hFF, {24'h0, c.rc});
    if (c.rc == `PCQ_RC_SUCCESS && c.cmd == `PCQ_CMD_GET_SNK)
      exp_snk = c.cp;
    if (c.rc == `PCQ_RC_SUCCESS && c.cmd == `PCQ_CMD_GET_SRC)
      exp_src = c.cp;
    wb_xfer(`PCQ_IDX_RX_SNK, 1'b0, 32'h0, q);
    check("received_sink_capabilities", q & 32'hFF, {24'h0, exp_snk});
    wb_xfer(`PCQ_IDX_RX_SRC, 1'b0, 32'h0, q);
    check("received_source_capabilities", q & 32'hFF, {24'h0, exp_src});
    st = {c.rc == `PCQ_RC_TIMEOUT, c.rc == `PCQ_RC_REJECTED, 1'b1};
    wb_xfer(`PCQ_IDX_IRQ_STAT, 1'b0, 32'h0, q);
    check("irq status", q & 32'h7, {29'h0, st});
    check("irq line", {31'h0, irq_o}, {31'h0, |(st & c.msk)});
    wb_xfer(`PCQ_IDX_IRQ_STAT, 1'b1, 32'h7, q);
    @(posedge ref_clk);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
  endtask

  // reset values, an unmapped place, the task table, a bad command
  initial
  begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    wb_xfer(`PCQ_IDX_RX_SRC, 1'b0, 32'h0, q);
    check("rx source reset", q & 32'hFF, 32'h0);
    wb_xfer(`PCQ_IDX_RX_SNK, 1'b0, 32'h0, q);
    check("rx sink reset", q & 32'hFF, 32'h0);
    wb_xfer(`PCQ_IDX_IRQ_MASK, 1'b0, 32'h0, q);
    check("mask reset", q & 32'h7, 32'h0);
    wb_xfer(8'h20, 1'b0, 32'h0, q);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 10; i++)
      run_case(tbl[i]);
    wb_xfer(`PCQ_IDX_TASK_CMD, 1'b1, 32'h07, q);
    wb_xfer(`PCQ_IDX_TASK_DATA, 1'b0, 32'h0, q);
    check("bad command", q & 32'hFF, {24'h0, `PCQ_RC_BAD_CMD});
    check("bad command irq", {31'h0, irq_o}, 32'h0);
    complete_run();
  end
endmodule
